// File: design/gfr_top.v
// Fault response configuration and reaction for a three-phase pre-driver
// Function
// RULE1 - Report select bit 12 enables illegal-input status and latched fault pin
// RULE2 - Per-phase illegal-input detect disable bits: U bit 8, V 4, W 0
// RULE3 - Disabled phase with both inputs high drives both outputs high, silently
// RULE4 - Limit field 13:12 selects 8, 16, 32 us or no limit
// RULE5 - Controller should avoid the unlimited current setting normally
// RULE6 - Undefined field codes are ignored, other fields still update
// RULE7 - Gate overvoltage code 0 disables, code 1 reports and continues
// RULE8 - Gate overvoltage codes 2 to 5 select shutdown scope and latching
// RULE9 - Drain fault fields 7:4 and 3:0; code 0 off, 1 report
// RULE10 - Drain codes 2 and 3 shut off the faulted phase, 3 latched
// RULE11 - Drain codes 4,5 shut all nine, 6,7 shut six motor channels
// RULE12 - Drain codes 8 and 9 shut nine plus charge pump, 9 latched
// RULE13 - Controller should avoid non-latched shutdown codes normally
// RULE14 - Latched status clears on write of 1 only once fault is gone
// RULE15 - Latched shutdown holds until cleared; non-latched releases with fault
`timescale 1ns/1ns
`include "gfr_regs.vh"
module gfr_top (
  input wire mclk,
  input wire resetn,
  input wire wr_en,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire [2:0] hs_in,
  input wire [2:0] ls_in,
  input wire [5:0] gate_ov,
  input wire [5:0] drain_fault,
  input wire en_cp,
  output reg [15:0] rdata,
  output reg [2:0] hs_out,
  output reg [2:0] ls_out,
  output reg [2:0] aux_out,
  input wire [2:0] aux_in,
  output reg cp_on,
  output reg fault_out_n
);
  // Status and clear map: gate overvoltage bits 11,9,7,5,3,1 and drain
  // bits 10,8,6,4,2,0, pairs per phase U,V,W high then low
  // Illegal-input status sits at bits 14:12, phase U lowest
  reg illegal_input_report_sel_reg;
  reg [2:0] ill_dis_reg;
  reg [1:0] ilim_sel_reg;
  reg [2:0] gate_overvolt_action_reg;
  reg [3:0] high_side_drain_fault_action_reg;
  reg [3:0] low_side_drain_fault_action_reg;
  reg [11:0] stat_reg;
  reg [11:0] stat_next;
  reg [2:0] ill_stat_reg;
  reg [2:0] ill_stat_next;
  reg [2:0] ph_off_reg;
  reg [2:0] ph_off_next;
  reg six_off_reg;
  reg six_off_next;
  reg nine_off_reg;
  reg nine_off_next;
  reg cp_off_reg;
  reg cp_off_next;
  wire [2:0] hs_s;
  wire [2:0] ls_s;
  wire [5:0] gov_s;
  wire [5:0] dsf_s;
  wire [5:0] lim;
  wire [5:0] drv;
  reg [11:0] live;
  reg [2:0] ph_now;
  reg six_now;
  reg nine_now;
  reg cp_now;
  reg [15:0] rd_val;
  reg [2:0] illegal;
  reg [3:0] act;
  integer p;
  // Own loop index so the output process never shares the decode index
  integer q;

  // Command and fault pins cross into the clock domain
  gfr_sync #(.W(6)) u_sync_in (
    .mclk(mclk),
    .resetn(resetn),
    .din({hs_in, ls_in}),
    .dout({hs_s, ls_s})
  );
  gfr_sync #(.W(12)) u_sync_flt (
    .mclk(mclk),
    .resetn(resetn),
    .din({gate_ov, drain_fault}),
    .dout({gov_s, dsf_s})
  );

  // Timer drive bits packed so no select ever falls out of range
  assign drv = {ls_s, hs_s};

  // One limit timer per motor output, indexed hs U,V,W then ls U,V,W
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_lim
      gfr_ilim u_lim (
        .mclk(mclk),
        .resetn(resetn),
        .drive(drv[g]),
        .sel(ilim_sel_reg),
        .limit(lim[g])
      );
    end
  endgenerate

  // Register writes; illegal codes leave only their own field alone
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      illegal_input_report_sel_reg <= 1'b0;
      ill_dis_reg <= 3'h0;
      ilim_sel_reg <= `GFR_ILIM_RST;
      gate_overvolt_action_reg <= `GFR_GOV_RST;
      high_side_drain_fault_action_reg <= `GFR_HSD_RST;
      low_side_drain_fault_action_reg <= `GFR_LSD_RST;
    end else if (wr_en) begin
      if (addr == `GFR_ILL_CTRL_OFS) begin
        illegal_input_report_sel_reg <= wdata[`GFR_REPORT_SEL_BIT]; // [RULE1]
        ill_dis_reg[0] <= wdata[`GFR_DIS_U_BIT]; // [RULE2]
        ill_dis_reg[1] <= wdata[`GFR_DIS_V_BIT]; // [RULE2]
        ill_dis_reg[2] <= wdata[`GFR_DIS_W_BIT]; // [RULE2]
      end else if (addr == `GFR_ILIM_TIME_OFS) begin
        // All four limit codes are defined, so this field always updates
        ilim_sel_reg <= wdata[`GFR_ILIM_LSB+1:`GFR_ILIM_LSB]; // [RULE4]
      end else if (addr == `GFR_FET_ACT_OFS) begin
        if (wdata[`GFR_GOV_LSB+2:`GFR_GOV_LSB] <= 3'h5) begin
          gate_overvolt_action_reg <=
            wdata[`GFR_GOV_LSB+2:`GFR_GOV_LSB]; // [RULE6]
        end
        if (wdata[`GFR_HSD_LSB+3:`GFR_HSD_LSB] <= 4'h9) begin
          high_side_drain_fault_action_reg <=
            wdata[`GFR_HSD_LSB+3:`GFR_HSD_LSB]; // [RULE6]
        end
        if (wdata[`GFR_LSD_LSB+3:`GFR_LSD_LSB] <= 4'h9) begin
          low_side_drain_fault_action_reg <=
            wdata[`GFR_LSD_LSB+3:`GFR_LSD_LSB]; // [RULE6]
        end
      end
    end
  end

  // Decode faults into live conditions and shutdown requests
  always @* begin
    live = 12'h000;
    ph_now = 3'h0;
    six_now = 1'b0;
    nine_now = 1'b0;
    cp_now = 1'b0;
    ph_off_next = ph_off_reg;
    six_off_next = six_off_reg;
    nine_off_next = nine_off_reg;
    cp_off_next = cp_off_reg;
    act = 4'h0;
    for (p = 0; p < 3; p = p + 1) begin
      // Status positions: U uses 11..8, V 7..4, W 3..0
      live[11-4*p] = gov_s[p] && gate_overvolt_action_reg != 3'h0; // [RULE7]
      live[9-4*p] = gov_s[p+3] && gate_overvolt_action_reg != 3'h0;
      live[10-4*p] = dsf_s[p] &&
        high_side_drain_fault_action_reg != 4'h0; // [RULE9]
      live[8-4*p] = dsf_s[p+3] && low_side_drain_fault_action_reg != 4'h0;
    end
    // Gate overvoltage reaction; codes 2 to 4 release once the input drops
    if (|gov_s) begin
      case (gate_overvolt_action_reg)
        3'h2: nine_now = 1'b1; // [RULE8]
        3'h3: six_now = 1'b1; // [RULE8]
        3'h4: begin
          nine_now = 1'b1;
          cp_now = 1'b1; // [RULE8]
        end
        3'h5: begin
          nine_off_next = 1'b1;
          cp_off_next = 1'b1; // [RULE8] [RULE15]
        end
        default: begin
        end
      endcase
    end
    // Drain fault reaction, high side then low side
    // Several channels may fault at once; every request is ORed in
    for (p = 0; p < 6; p = p + 1) begin
      act = (p < 3) ? high_side_drain_fault_action_reg :
        low_side_drain_fault_action_reg;
      if (dsf_s[p]) begin
        case (act)
          4'h2: ph_now[p%3] = 1'b1; // [RULE10]
          4'h3: ph_off_next[p%3] = 1'b1; // [RULE10] [RULE15]
          4'h4: nine_now = 1'b1; // [RULE11]
          4'h5: nine_off_next = 1'b1; // [RULE11]
          4'h6: six_now = 1'b1; // [RULE11]
          4'h7: six_off_next = 1'b1; // [RULE11]
          4'h8: begin
            nine_now = 1'b1;
            cp_now = 1'b1; // [RULE12]
          end
          4'h9: begin
            nine_off_next = 1'b1;
            cp_off_next = 1'b1; // [RULE12]
          end
          default: begin
          end
        endcase
      end
    end
    // Illegal input: both commands high on an enabled phase
    illegal = hs_s & ls_s & ~ill_dis_reg; // [RULE2]
    // Status: set wins over clear; clear needs the fault gone
    stat_next = stat_reg | live;
    ill_stat_next = ill_stat_reg;
    if (illegal_input_report_sel_reg) begin
      ill_stat_next = ill_stat_reg | illegal; // [RULE1]
    end
    // A clear landing on a live fault leaves that bit set; the
    // controller has to repeat it once the condition has gone
    if (wr_en && addr == `GFR_CLR_OFS) begin
      stat_next = stat_next & ~(wdata[11:0] & ~live); // [RULE14]
      ill_stat_next = ill_stat_next & ~(wdata[14:12] & ~illegal); // [RULE14]
      // Latched shutdowns drop with their status once all is quiet
      if ((stat_next == 12'h000) && (ill_stat_next == 3'h0)) begin
        ph_off_next = 3'h0; // [RULE15]
        six_off_next = 1'b0;
        nine_off_next = 1'b0;
        cp_off_next = 1'b0;
      end
    end
  end

  // Status, latched shutdowns and read data
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      stat_reg <= 12'h000;
      ill_stat_reg <= 3'h0;
      ph_off_reg <= 3'h0;
      six_off_reg <= 1'b0;
      nine_off_reg <= 1'b0;
      cp_off_reg <= 1'b0;
      rdata <= 16'h0000;
    end else begin
      stat_reg <= stat_next;
      ill_stat_reg <= ill_stat_next;
      ph_off_reg <= ph_off_next;
      six_off_reg <= six_off_next;
      nine_off_reg <= nine_off_next;
      cp_off_reg <= cp_off_next;
      if (rd_en) begin
        rdata <= rd_val;
      end
    end
  end

  // Read decode at write offset plus 0x80
  // Unmapped addresses read as zero
  always @* begin
    rd_val = 16'h0000;
    if (addr == (`GFR_ILL_CTRL_OFS | `GFR_RD_BIT)) begin
      rd_val = {3'h0, illegal_input_report_sel_reg, 3'h0, ill_dis_reg[0],
        3'h0, ill_dis_reg[1], 3'h0, ill_dis_reg[2]};
    end else if (addr == (`GFR_ILIM_TIME_OFS | `GFR_RD_BIT)) begin
      rd_val = {2'h0, ilim_sel_reg, 12'h000};
    end else if (addr == (`GFR_FET_ACT_OFS | `GFR_RD_BIT)) begin
      rd_val = {5'h00, gate_overvolt_action_reg,
        high_side_drain_fault_action_reg, low_side_drain_fault_action_reg};
    end else if (addr == (`GFR_STAT_OFS | `GFR_RD_BIT)) begin
      rd_val = {1'b0, ill_stat_reg, stat_reg};
    end
  end

  // Gate outputs: shutdowns and current limit force low; a disabled
  // illegal pattern passes straight through with both outputs high
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hs_out <= 3'h0;
      ls_out <= 3'h0;
      aux_out <= 3'h0;
      cp_on <= 1'b0;
      fault_out_n <= 1'b1;
    end else begin
      // Next-state shutdown flags let a new latch act in the same cycle
      for (q = 0; q < 3; q = q + 1) begin
        if (ph_now[q] || ph_off_next[q] || six_now || six_off_next ||
            nine_now || nine_off_next) begin
          hs_out[q] <= 1'b0; // [RULE10] [RULE11]
          ls_out[q] <= 1'b0;
        end else if (illegal[q]) begin
          hs_out[q] <= 1'b0; // Enabled detection blocks shoot-through
          ls_out[q] <= 1'b0;
        end else begin
          hs_out[q] <= hs_s[q] & ~lim[q]; // [RULE3] [RULE4]
          ls_out[q] <= ls_s[q] & ~lim[q+3]; // [RULE3]
        end
        aux_out[q] <= aux_in[q] & ~(nine_now | nine_off_next); // [RULE8]
      end
      cp_on <= en_cp & ~(cp_now | cp_off_next); // [RULE12]
      // Fault pin latched low while any status stands
      fault_out_n <= ~((|stat_next) || (|ill_stat_next)); // [RULE1] [RULE14]
    end
  end
endmodule // gfr_top

// File: common/gfr_regs.vh
// Register offsets, field positions, reset values and timing counts
`ifndef GFR_REGS_VH
`define GFR_REGS_VH
// Offsets of the three control registers, status and clear; register reads use offset plus 0x80
`define GFR_ILL_CTRL_OFS 8'h18
`define GFR_ILIM_TIME_OFS 8'h1c
`define GFR_FET_ACT_OFS 8'h24
`define GFR_STAT_OFS 8'h0c
`define GFR_CLR_OFS 8'h10
`define GFR_RD_BIT 8'h80
// Field positions
`define GFR_REPORT_SEL_BIT 12
`define GFR_DIS_U_BIT 8
`define GFR_DIS_V_BIT 4
`define GFR_DIS_W_BIT 0
`define GFR_ILIM_LSB 12
`define GFR_GOV_LSB 8
`define GFR_HSD_LSB 4
`define GFR_LSD_LSB 0
// Reset values
`define GFR_ILL_CTRL_RST 16'h0000
`define GFR_ILIM_RST 2'h0
`define GFR_GOV_RST 3'h5
`define GFR_HSD_RST 4'h7
`define GFR_LSD_RST 4'h7
// Current limit times in microseconds and cycles at 250 MHz
`define GFR_CLK_MHZ 250
`define GFR_ILIM_T0_US 8
`define GFR_ILIM_T1_US 16
`define GFR_ILIM_T2_US 32
// Cycle counts are microseconds times MHz, sized for the 14-bit timer
`define GFR_ILIM_C0 14'h07d0
`define GFR_ILIM_C1 14'h0fa0
`define GFR_ILIM_C2 14'h1f40
`endif

// File: design/gfr_sync.v
// Three-stage input synchroniser that accepts a change when stages agree
`timescale 1ns/1ns
module gfr_sync #(
  parameter W = 1
) (
  input wire mclk,
  input wire resetn,
  input wire [W-1:0] din,
  output reg [W-1:0] dout
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  integer i;

  // First stage feeds only the second
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      s1_reg <= {W{1'b0}};
      s2_reg <= {W{1'b0}};
      s3_reg <= {W{1'b0}};
      dout <= {W{1'b0}};
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      for (i = 0; i < W; i = i + 1) begin
        if (s2_reg[i] == s3_reg[i]) begin
          dout[i] <= s3_reg[i];
        end
      end
    end
  end
endmodule // gfr_sync

// File: design/gfr_ilim.v
// Gate output current limit timer for one pre-driver channel
`timescale 1ns/1ns
`include "gfr_regs.vh"
module gfr_ilim (
  input wire mclk,
  input wire resetn,
  input wire drive,
  input wire [1:0] sel,
  output reg limit
);
  reg [13:0] cnt_reg;
  reg drive_d_reg;
  reg [13:0] lim;

  // Duration selected by the limit field; code 3 never limits
  always @* begin
    case (sel)
      2'h0: lim = `GFR_ILIM_C0;
      2'h1: lim = `GFR_ILIM_C1;
      default: lim = `GFR_ILIM_C2;
    endcase
  end

  // Count from each drive edge; limit once the time has elapsed
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_reg <= 14'h0000;
      drive_d_reg <= 1'b0;
      limit <= 1'b0;
    end else begin
      drive_d_reg <= drive;
      if (drive != drive_d_reg) begin
        cnt_reg <= 14'h0000;
        limit <= 1'b0;
      end else if (sel == 2'h3) begin
        limit <= 1'b0; // [RULE4]
      end else if (cnt_reg >= lim) begin
        limit <= 1'b1; // [RULE4]
      end else begin
        cnt_reg <= cnt_reg + 14'h0001;
      end
    end
  end
endmodule // gfr_ilim

// File: sim/gfr_props.sv
// Port checker for the fault response block
`timescale 1ns/1ns
module gfr_props (
  input wire mclk,
  input wire resetn,
  input wire rd_en,
  input wire [7:0] addr,
  input wire [2:0] hs_in,
  input wire [2:0] ls_in,
  input wire [5:0] gate_ov,
  input wire [5:0] drain_fault,
  input wire en_cp,
  input wire [15:0] rdata,
  input wire [2:0] hs_out,
  input wire cp_on,
  input wire fault_out_n,
  input wire wr_en
);
  reg [3:0] n_cause;
  reg [3:0] n_clr;
  reg [3:0] n_cp;
  reg [3:0] n_hs;
  function [3:0] sat(input c, input [3:0] n);
    sat = c ? 4'h0 : (n == 4'hf ? n : n + 4'h1);
  endfunction
  // Cycles since each cause was seen; saturates so it never wraps
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      n_cause <= 4'hf;
      n_clr <= 4'hf;
      n_cp <= 4'hf;
      n_hs <= 4'hf;
    end else begin
      n_cause <= sat(|{gate_ov, drain_fault, hs_in & ls_in}, n_cause);
      n_clr <= sat(wr_en && addr == 8'h10, n_clr);
      n_cp <= sat(en_cp, n_cp);
      n_hs <= sat(|hs_in, n_hs);
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  a_fault_has_cause: assert property (
    $fell(fault_out_n) |-> n_cause < 4'ha)
    else $error("fault pin fell with no cause");
  a_fault_held_clr: assert property (
    $rose(fault_out_n) |-> n_clr < 4'h8)
    else $error("fault pin rose with no clear write");
  a_pump_needs_req: assert property (
    cp_on |-> n_cp < 4'h8)
    else $error("charge pump on without request");
  a_drive_has_cmd: assert property (
    |hs_out |-> n_hs < 4'h8)
    else $error("gate output high without command");
  a_ill_reserved: assert property (
    rd_en && addr == 8'h98 |=> (rdata & 16'heeee) == 16'h0)
    else $error("illegal input control reserved bits set");
  a_ilim_reserved: assert property (
    rd_en && addr == 8'h9c |=> (rdata & 16'hcfff) == 16'h0)
    else $error("limit time reserved bits set");
  a_act_codes: assert property (
    rd_en && addr == 8'ha4 |=> rdata[15:11] == 5'h0 &&
    rdata[10:8] < 3'h6 && rdata[7:4] < 4'ha && rdata[3:0] < 4'ha)
    else $error("undefined action code stored");
  a_stat_pin_match: assert property (
    rd_en && addr == 8'h8c && fault_out_n && n_cause == 4'hf
    |=> rdata == 16'h0)
    else $error("status set while fault pin high");
  c_fault_fell: cover property ($fell(fault_out_n));
  c_fault_rose: cover property ($rose(fault_out_n));
  c_pump_off: cover property ($fell(cp_on));
endmodule // gfr_props
bind gfr_top gfr_props u_gfr_props (.mclk(mclk), .resetn(resetn),
  .rd_en(rd_en), .addr(addr), .hs_in(hs_in), .ls_in(ls_in),
  .gate_ov(gate_ov), .drain_fault(drain_fault), .en_cp(en_cp),
  .rdata(rdata), .hs_out(hs_out), .cp_on(cp_on),
  .fault_out_n(fault_out_n), .wr_en(wr_en));

// File: sim/gfr_mcu_model.sv
// Controller model driving the phase command pins
`timescale 1ns/1ns
module gfr_mcu_model (
  input wire mclk,
  input wire [2:0] hs_cmd,
  input wire [2:0] ls_cmd,
  output reg [2:0] hs_in,
  output reg [2:0] ls_in
);
  reg [2:0] hs_q;
  reg [2:0] ls_q;
  // Take the commands at the rising edge, free of any race with the bench
  always @(posedge mclk) begin
    hs_q <= hs_cmd;
    ls_q <= ls_cmd;
  end
  // Move the pins on the falling edge so the block never samples mid-change
  always @(negedge mclk) begin
    hs_in <= hs_q;
    ls_in <= ls_q;
  end
endmodule // gfr_mcu_model

// File: sim/gfr_top_bench.sv
// Self-checking bench for the fault response block
`timescale 1ns/1ns
module gfr_top_bench;
  reg mclk, resetn, wr_en, rd_en, en_cp;
  reg [7:0] addr;
  reg [15:0] wdata;
  reg [5:0] gate_ov, drain_fault;
  reg [2:0] hs_cmd, ls_cmd;
  wire [2:0] hs_in, ls_in, hs_out, ls_out, aux_out;
  wire [15:0] rdata;
  wire cp_on, fault_out_n;
  integer n_errors, n_tests, cyc, c;
  gfr_mcu_model u_gfr_mcu_model (.mclk(mclk), .hs_cmd(hs_cmd),
    .ls_cmd(ls_cmd), .hs_in(hs_in), .ls_in(ls_in));
  gfr_top u_gfr_top (.mclk(mclk), .resetn(resetn), .wr_en(wr_en),
    .rd_en(rd_en), .addr(addr), .wdata(wdata), .hs_in(hs_in),
    .ls_in(ls_in), .gate_ov(gate_ov), .drain_fault(drain_fault),
    .en_cp(en_cp), .rdata(rdata), .hs_out(hs_out), .ls_out(ls_out),
    .aux_out(aux_out), .aux_in(3'h7), .cp_on(cp_on),
    .fault_out_n(fault_out_n));
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  task report_and_stop;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  // A hang counts as a mismatch
  always @(posedge mclk) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      n_errors = n_errors + 1;
      report_and_stop;
    end
  end
  task chk(input [63:0] nm, input [15:0] x, input [15:0] g);
    begin
      n_tests = n_tests + 1;
      if (g !== x) begin
        n_errors = n_errors + 1;
        $display("CHECK FAILED %0s exp %h got %h", nm, x, g);
      end
    end
  endtask
  task wt(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(negedge mclk);
      wr_en = 1;
      addr = a;
      wdata = d;
      @(negedge mclk);
      wr_en = 0;
    end
  endtask
  task rd_chk(input [7:0] a, input [15:0] x);
    begin
      @(negedge mclk);
      rd_en = 1;
      addr = a;
      @(negedge mclk);
      rd_en = 0;
      chk("register", x, rdata);
    end
  endtask
  // Pin view packed as fault pin, pump, relays, high sides
  task pins(input [7:0] x);
    chk("pins", {8'h0, x}, {8'h0, fault_out_n, cp_on, aux_out, hs_out});
  endtask
  function [7:0] scope(input [3:0] k);
    case (k)
      4'h0: scope = 8'hff;
      4'h1: scope = 8'h7f;
      4'h2, 4'h3: scope = 8'h7e;
      4'h4, 4'h5: scope = 8'h40;
      4'h6, 4'h7: scope = 8'h78;
      default: scope = 8'h00;
    endcase
  endfunction
  // Raise one fault on phase U high side, clear early, then properly
  task run(input [3:0] k, input [15:0] v, input g, input [15:0] st);
    begin
      wr(8'h24, v);
      gate_ov = {5'h0, g};
      drain_fault = {5'h0, !g};
      wt(10);
      pins(scope(k));
      rd_chk(8'h8c, k == 0 ? 16'h0 : st);
      wr(8'h10, 16'h7fff);
      wt(10);
      pins(scope(k));
      gate_ov = 0;
      drain_fault = 0;
      wt(10);
      pins((k > 2 && k[0]) ? scope(k) : (k == 0 ? 8'hff : 8'h7f));
      wr(8'h10, 16'h7fff);
      wt(10);
      pins(8'hff);
    end
  endtask
  initial begin
    resetn = 0;
    wr_en = 0;
    rd_en = 0;
    addr = 0;
    wdata = 0;
    gate_ov = 0;
    drain_fault = 0;
    hs_cmd = 0;
    ls_cmd = 0;
    en_cp = 1;
    n_errors = 0;
    n_tests = 0;
    cyc = 0;
    wt(20);
    resetn = 1;
    rd_chk(8'h98, 16'h0);
    rd_chk(8'h9c, 16'h0);
    rd_chk(8'ha4, 16'h0577);
    wr(8'h24, 16'h0599);
    wr(8'h24, 16'h07ab);
    rd_chk(8'ha4, 16'h0599);
    wr(8'h24, 16'h06a3);
    rd_chk(8'ha4, 16'h0593);
    wr(8'h18, 16'h1111);
    rd_chk(8'h98, 16'h1111);
    $display("register test done");
    // Shortest limit: 2000 cycles of steady drive, then off
    hs_cmd = 3'h7;
    wt(1990);
    pins(8'hff);
    wt(30);
    pins(8'hf8);
    hs_cmd = 0;
    // No limit, so the long drives below are never cut
    wr(8'h1c, 16'h3000);
    rd_chk(8'h9c, 16'h3000);
    hs_cmd = 3'h7;
    ls_cmd = 3'h1;
    wt(10);
    pins(8'hff);
    chk("low side", 16'h1, {13'h0, ls_out});
    wr(8'h18, 16'h1000);
    wt(10);
    pins(8'h7e);
    rd_chk(8'h8c, 16'h1000);
    ls_cmd = 0;
    wt(10);
    wr(8'h10, 16'h0000);
    wt(10);
    pins(8'h7f);
    wr(8'h10, 16'h7fff);
    wt(10);
    pins(8'hff);
    wr(8'h18, 16'h0000);
    ls_cmd = 3'h1;
    wt(10);
    pins(8'hfe);
    rd_chk(8'h8c, 16'h0);
    ls_cmd = 0;
    $display("illegal input test done");
    en_cp = 0;
    wt(10);
    pins(8'hbf);
    en_cp = 1;
    for (c = 0; c < 10; c = c + 1)
      run(c[3:0], {8'h05, c[3:0], 4'h0}, 1'b0, 16'h0400);
    $display("drain fault test done");
    for (c = 0; c < 6; c = c + 1)
      run(c < 2 ? c[3:0] : (c == 5 ? 4'h9 : c[2:0] * 2),
        {5'h0, c[2:0], 8'h00}, 1'b1, 16'h0800);
    $display("gate overvoltage test done");
    wr(8'h24, 16'h0599);
    wr(8'h1c, 16'h0000);
    rd_chk(8'ha4, 16'h0599);
    rd_chk(8'h9c, 16'h0000);
    report_and_stop;
  end
endmodule // gfr_top_bench
